// ==== logic/tssc_defs.vh ====
`ifndef TSSC_DEFS_VH
`define TSSC_DEFS_VH

// ==========================================
// Register offsets (byte addresses)
`define TSSC_ADDR_W 8
`define TSSC_OFS_STATUS 8'h00
`define TSSC_OFS_SLOT 8'h04
`define TSSC_OFS_INT_EN 8'h08
`define TSSC_OFS_FRAME_CFG 8'h0c

// ==========================================
// Status register bit positions
`define TSSC_ST_UNDERRUN 0
`define TSSC_ST_EARLY_SYNC 1
`define TSSC_ST_CLK_FAIL 2
`define TSSC_ST_PARITY 3
`define TSSC_ST_DMA_ERR 7
`define TSSC_ST_ERR_SUM 8

// ==========================================
// Slot register field
`define TSSC_SLOT_W 10
`define TSSC_SLOT_RESET 10'h17f
`define TSSC_SLOT_DIT_LAST 10'h17f

// ==========================================
// Frame configuration fields
`define TSSC_CFG_SLOTS_LSB 0
`define TSSC_CFG_SLOTS_W 5
`define TSSC_CFG_DIT_BIT 8
`define TSSC_CFG_BITS_LSB 16
`define TSSC_CFG_BITS_W 5
`define TSSC_CFG_RUN_BIT 31

// ==========================================
// Reset values
`define TSSC_INT_EN_RESET 32'h00000000
`define TSSC_CFG_RESET 32'h00000000
`define TSSC_STATUS_RESET 4'h0

`endif

// ==== logic/tssc_sync.v ====
`timescale 1ns/100ps
// ==========================================
// Two-stage synchroniser for pin inputs
module tssc_sync #(
    parameter WIDTH = 2
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// ==== logic/tssc_slot_counter.v ====
`timescale 1ns/100ps
`include "tssc_defs.vh"
// ==========================================
// Transmit time-slot counter
module tssc_slot_counter (
    input wire clk,
    input wire rst,
    input wire hold,
    input wire restart,
    input wire advance,
    input wire [`TSSC_SLOT_W-1:0] last_slot,
    output reg [`TSSC_SLOT_W-1:0] count,
    output wire at_last
);
    reg [`TSSC_SLOT_W-1:0] next_count;

    assign at_last = (count == last_slot);

    always @* begin
        next_count = count;
        if (hold) begin
            next_count = `TSSC_SLOT_RESET;
        end else if (restart) begin
            next_count = {`TSSC_SLOT_W{1'b0}};
        end else if (advance) begin
            if (at_last) begin
                next_count = {`TSSC_SLOT_W{1'b0}};
            end else begin
                next_count = count + 10'h001;
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= `TSSC_SLOT_RESET;
        end else begin
            count <= next_count;
        end
    end
endmodule

// ==== logic/tssc_top.v ====
`timescale 1ns/100ps
`include "tssc_defs.vh"
// Operation
// - A clock-failure report from the clock checker sets status bit 2.
// - The transmit interrupt is high while any error flag and its enable bit are both set.
// - A frame sync arriving before the last bit of the last slot sets status bit 1.
// - A buffer-to-shift move with no buffer write since the previous move sets status bit 0.
// - Each error flag clears only on a written one to its bit; a written zero leaves it.
// - The slot register shows the 10-bit current slot count in bits 9 to 0, range 0 to 383.
// - While the transmitter is in reset the slot count holds 383 so the next count is 0.
// - TDM frames are limited to 32 slots; only the digital audio mode counts up to 383.
// - Slot register bits 31 to 10 read zero and ignore writes.
// - Status bit 8 reads the OR of the underrun, early-sync, clock-fail and DMA error flags.
// - Status bit 3 mirrors bit 0 of the slot count.
module tssc_top (
    input wire REF_CLK,
    input wire RST,
    input wire [`TSSC_ADDR_W-1:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [31:0] REG_RDATA,
    input wire TX_BIT_CLK,
    input wire TX_FRAME_SYNC,
    input wire CLK_FAIL_EVENT,
    input wire TX_BUF_WRITE,
    input wire TX_DMA_ERROR,
    output wire TX_INTERRUPT,
    output reg TX_SLOT_START,
    output wire [`TSSC_SLOT_W-1:0] TX_SLOT_COUNT
);

    // ==========================================
    // Address decode
    function addr_hit;
        input [`TSSC_ADDR_W-1:0] addr;
        input [`TSSC_ADDR_W-1:0] ofs;
        begin
            addr_hit = (addr == ofs);
        end
    endfunction

    // ==========================================
    // Flag positions within a status-shaped word
    function [3:0] flag_pick;
        input [31:0] word;
        begin
            flag_pick = {word[`TSSC_ST_DMA_ERR],
                         word[`TSSC_ST_CLK_FAIL],
                         word[`TSSC_ST_EARLY_SYNC],
                         word[`TSSC_ST_UNDERRUN]};
        end
    endfunction

    wire wr_status;
    wire wr_int_en;
    wire wr_cfg;
    wire rd_status;
    wire rd_slot;
    wire rd_int_en;
    wire rd_cfg;

    assign wr_status = REG_WR & addr_hit(REG_ADDR, `TSSC_OFS_STATUS);
    assign wr_int_en = REG_WR & addr_hit(REG_ADDR, `TSSC_OFS_INT_EN);
    assign wr_cfg = REG_WR & addr_hit(REG_ADDR, `TSSC_OFS_FRAME_CFG);
    assign rd_status = REG_RD & addr_hit(REG_ADDR, `TSSC_OFS_STATUS);
    assign rd_slot = REG_RD & addr_hit(REG_ADDR, `TSSC_OFS_SLOT);
    assign rd_int_en = REG_RD & addr_hit(REG_ADDR, `TSSC_OFS_INT_EN);
    assign rd_cfg = REG_RD & addr_hit(REG_ADDR, `TSSC_OFS_FRAME_CFG);

    // ==========================================
    // Control registers
    reg [31:0] tx_interrupt_enable_reg;
    reg [31:0] frame_cfg;

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            tx_interrupt_enable_reg <= `TSSC_INT_EN_RESET;
        end else if (wr_int_en) begin
            tx_interrupt_enable_reg <= REG_WDATA;
        end
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            frame_cfg <= `TSSC_CFG_RESET;
        end else if (wr_cfg) begin
            frame_cfg <= REG_WDATA;
        end
    end

    wire tx_run;
    wire digital_audio_iface_mode;
    wire [`TSSC_CFG_SLOTS_W-1:0] tdm_last_slot;
    wire [`TSSC_CFG_BITS_W-1:0] last_bit;
    wire [`TSSC_SLOT_W-1:0] last_slot;

    assign tx_run = frame_cfg[`TSSC_CFG_RUN_BIT];
    assign digital_audio_iface_mode = frame_cfg[`TSSC_CFG_DIT_BIT];
    assign tdm_last_slot = frame_cfg[`TSSC_CFG_SLOTS_LSB +: `TSSC_CFG_SLOTS_W];
    assign last_bit = frame_cfg[`TSSC_CFG_BITS_LSB +: `TSSC_CFG_BITS_W];

    // A 5-bit field cannot name more than 32 TDM slots
    assign last_slot = digital_audio_iface_mode ? `TSSC_SLOT_DIT_LAST :
                       {5'h00, tdm_last_slot};

    // ==========================================
    // Link pin synchronisation
    wire [1:0] pins_sync;
    wire bclk_s;
    wire fsync_s;

    tssc_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(REF_CLK),
        .rst(RST),
        .din({TX_FRAME_SYNC, TX_BIT_CLK}),
        .dout(pins_sync)
    );

    assign bclk_s = pins_sync[0];
    assign fsync_s = pins_sync[1];

    // ==========================================
    // Link edge detection
    reg bclk_prev;
    reg fsync_prev;
    wire bit_edge;
    wire frame_start;

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            bclk_prev <= 1'b0;
        end else begin
            bclk_prev <= bclk_s;
        end
    end

    // Frame sync is sampled on bit clock rising edges only
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            fsync_prev <= 1'b0;
        end else if (bit_edge) begin
            fsync_prev <= fsync_s;
        end
    end

    assign bit_edge = bclk_s & ~bclk_prev;
    assign frame_start = bit_edge & tx_run & fsync_s & ~fsync_prev;

    // ==========================================
    // Bit and slot timing
    reg started;
    reg next_started;
    reg [`TSSC_CFG_BITS_W-1:0] bit_cnt;
    reg [`TSSC_CFG_BITS_W-1:0] next_bit_cnt;
    wire bit_last;
    wire slot_at_last;
    wire slot_advance;
    wire transfer;
    wire early_sync;
    wire [`TSSC_SLOT_W-1:0] tx_slot_count;

    assign bit_last = (bit_cnt == last_bit);
    assign slot_advance = bit_edge & tx_run & started & bit_last & ~frame_start;
    assign transfer = frame_start | slot_advance;

    // Expected sync comes right after the last bit of the last slot
    assign early_sync = frame_start & started & ~(slot_at_last & bit_last);

    always @* begin
        next_started = started;
        if (~tx_run) begin
            next_started = 1'b0;
        end else if (frame_start) begin
            next_started = 1'b1;
        end
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            started <= 1'b0;
        end else begin
            started <= next_started;
        end
    end

    always @* begin
        next_bit_cnt = bit_cnt;
        if (~tx_run | frame_start) begin
            next_bit_cnt = {`TSSC_CFG_BITS_W{1'b0}};
        end else if (bit_edge & started) begin
            if (bit_last) begin
                next_bit_cnt = {`TSSC_CFG_BITS_W{1'b0}};
            end else begin
                next_bit_cnt = bit_cnt + 5'h01;
            end
        end
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            bit_cnt <= {`TSSC_CFG_BITS_W{1'b0}};
        end else begin
            bit_cnt <= next_bit_cnt;
        end
    end

    // ==========================================
    // Slot counter
    tssc_slot_counter u_slot (
        .clk(REF_CLK),
        .rst(RST),
        .hold(~tx_run),
        .restart(frame_start),
        .advance(slot_advance),
        .last_slot(last_slot),
        .count(tx_slot_count),
        .at_last(slot_at_last)
    );

    // ==========================================
    // Slot outputs
    assign TX_SLOT_COUNT = tx_slot_count;

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            TX_SLOT_START <= 1'b0;
        end else begin
            TX_SLOT_START <= transfer;
        end
    end

    // ==========================================
    // Buffer service tracking
    reg buf_written;
    reg next_buf_written;
    wire underrun;

    assign underrun = transfer & ~buf_written;

    // A write in the same cycle as a move counts for the next move
    always @* begin
        next_buf_written = (buf_written & ~transfer) | TX_BUF_WRITE;
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            buf_written <= 1'b0;
        end else begin
            buf_written <= next_buf_written;
        end
    end

    // ==========================================
    // Sticky error flags: {dma, clock fail, early sync, underrun}
    wire [3:0] flag_set;
    wire [3:0] flag_clr;
    reg [3:0] flags;
    wire [3:0] next_flags;

    assign flag_set = {TX_DMA_ERROR, CLK_FAIL_EVENT, early_sync, underrun};
    assign flag_clr = flag_pick(REG_WDATA) & {4{wr_status}};
    // Set wins over a simultaneous clear
    assign next_flags = (flags & ~flag_clr) | flag_set;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
            always @(posedge REF_CLK or posedge RST) begin
                if (RST) begin
                    flags[gi] <= 1'b0;
                end else begin
                    flags[gi] <= next_flags[gi];
                end
            end
        end
    endgenerate

    // ==========================================
    // Flag views and error summary
    wire tx_underrun_flag;
    wire tx_early_sync_flag;
    wire tx_clock_fail_flag;
    wire tx_dma_error_flag;
    wire tx_error_summary;
    wire tx_slot_parity_bit;

    assign tx_underrun_flag = flags[0];
    assign tx_early_sync_flag = flags[1];
    assign tx_clock_fail_flag = flags[2];
    assign tx_dma_error_flag = flags[3];
    assign tx_error_summary = |flags;
    assign tx_slot_parity_bit = tx_slot_count[0];

    // ==========================================
    // Interrupt
    wire [3:0] int_en;

    assign int_en = flag_pick(tx_interrupt_enable_reg);
    assign TX_INTERRUPT = |(flags & int_en);

    // ==========================================
    // Register read
    reg [31:0] tx_status_reg;
    reg [31:0] tx_slot_reg;
    reg [31:0] next_rdata;

    always @* begin
        tx_status_reg = 32'h00000000;
        tx_status_reg[`TSSC_ST_UNDERRUN] = tx_underrun_flag;
        tx_status_reg[`TSSC_ST_EARLY_SYNC] = tx_early_sync_flag;
        tx_status_reg[`TSSC_ST_CLK_FAIL] = tx_clock_fail_flag;
        tx_status_reg[`TSSC_ST_PARITY] = tx_slot_parity_bit;
        tx_status_reg[`TSSC_ST_DMA_ERR] = tx_dma_error_flag;
        tx_status_reg[`TSSC_ST_ERR_SUM] = tx_error_summary;
    end

    always @* begin
        tx_slot_reg = {22'h000000, tx_slot_count};
    end

    always @* begin
        next_rdata = 32'h00000000;
        if (rd_status) begin
            next_rdata = tx_status_reg;
        end else if (rd_slot) begin
            next_rdata = tx_slot_reg;
        end else if (rd_int_en) begin
            next_rdata = tx_interrupt_enable_reg;
        end else if (rd_cfg) begin
            next_rdata = frame_cfg;
        end
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= 32'h00000000;
        end else begin
            REG_RDATA <= next_rdata;
        end
    end

endmodule

// ==== tb/tssc_props.sv ====
`timescale 1ns/100ps
`include "tssc_defs.vh"
module tssc_props (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [`TSSC_ADDR_W-1:0] REG_ADDR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic CLK_FAIL_EVENT,
    input wire logic TX_DMA_ERROR,
    input wire logic TX_INTERRUPT,
    input wire logic TX_SLOT_START,
    input wire logic [`TSSC_SLOT_W-1:0] TX_SLOT_COUNT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    wire st_rd = REG_RD && REG_ADDR == `TSSC_OFS_STATUS;
    wire sl_rd = REG_RD && REG_ADDR == `TSSC_OFS_SLOT;
    slot_range_a: assert property (TX_SLOT_COUNT <= 10'h17f) else $error("slot count out of range");
    slot_read_a: assert property (sl_rd |=> REG_RDATA == {22'h0, $past(TX_SLOT_COUNT)})
        else $error("slot register read wrong");
    parity_bit_a: assert property (st_rd |=> REG_RDATA[3] == $past(TX_SLOT_COUNT[0]))
        else $error("parity bit wrong");
    err_summary_a: assert property (st_rd |=> REG_RDATA[8] ==
        (REG_RDATA[0] | REG_RDATA[1] | REG_RDATA[2] | REG_RDATA[7])) else $error("error summary wrong");
    clk_fail_a: assert property (CLK_FAIL_EVENT ##1 st_rd |=> REG_RDATA[2]) else $error("clock fail not set");
    dma_flag_a: assert property (TX_DMA_ERROR ##1 st_rd |=> REG_RDATA[7] && REG_RDATA[8])
        else $error("dma flag not summed");
    int_cause_a: assert property (TX_INTERRUPT && st_rd |=>
        (REG_RDATA[0] | REG_RDATA[1] | REG_RDATA[2] | REG_RDATA[7])) else $error("interrupt without flag");
    slot_step_a: assert property ($changed(TX_SLOT_COUNT) |->
        TX_SLOT_COUNT == $past(TX_SLOT_COUNT) + 10'h1 || TX_SLOT_COUNT == 10'h0 || TX_SLOT_COUNT == 10'h17f)
        else $error("slot count jumped");
    start_pulse_a: assert property (TX_SLOT_START |=> !TX_SLOT_START) else $error("slot start too long");
    idle_rdata_a: assert property (!REG_RD |=> REG_RDATA == 32'h0) else $error("read data not cleared");
endmodule

bind tssc_top tssc_props u_props (
    .REF_CLK(REF_CLK),
    .RST(RST),
    .REG_ADDR(REG_ADDR),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA),
    .CLK_FAIL_EVENT(CLK_FAIL_EVENT),
    .TX_DMA_ERROR(TX_DMA_ERROR),
    .TX_INTERRUPT(TX_INTERRUPT),
    .TX_SLOT_START(TX_SLOT_START),
    .TX_SLOT_COUNT(TX_SLOT_COUNT)
);

// ==== tb/tssc_codec_model.sv ====
`timescale 1ns/100ps
module tssc_codec_model (
    input wire logic run,
    input wire logic early,
    input wire logic [9:0] frame_bits,
    output logic bclk,
    output logic fsync
);
    int i;
    initial begin
        bclk = 0;
        fsync = 0;
        forever begin
            wait (run);
            // Keep pin edges clear of the reference clock's rising edge
            #2;
            while (run) begin
                // One bit short when an early sync is ordered
                for (i = 0; i < frame_bits - early; i++) begin
                    fsync = (i == 0);
                    #40 bclk = 1;
                    #40 bclk = 0;
                end
            end
            fsync = 0;
        end
    end
endmodule

// ==== tb/tssc_top_test.sv ====
`timescale 1ns/100ps
`include "tssc_defs.vh"
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin failures++; $display("FAIL %0t %s", $time, m); end end
module tssc_top_test;
    logic ref_clk, rst, reg_wr, reg_rd, clk_fail, buf_wr, dma_err, feed, link_run, early;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, rdata;
    logic [9:0] frame_bits, c;
    wire [31:0] reg_rdata;
    wire bclk, fsync, tx_int, slot_start;
    wire [9:0] slot_count;
    int failures = 0;
    int checked = 0;

    tssc_top uut (.REF_CLK(ref_clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .TX_BIT_CLK(bclk), .TX_FRAME_SYNC(fsync),
        .CLK_FAIL_EVENT(clk_fail), .TX_BUF_WRITE(buf_wr), .TX_DMA_ERROR(dma_err), .TX_INTERRUPT(tx_int),
        .TX_SLOT_START(slot_start), .TX_SLOT_COUNT(slot_count));
    tssc_codec_model codec (.run(link_run), .early(early), .frame_bits(frame_bits), .bclk(bclk), .fsync(fsync));

    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Prompt writer refills the buffer after every move while feed is set
    always @(posedge ref_clk) buf_wr <= feed && slot_start;

    // ==========================================
    // Bus and link helpers
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge ref_clk);
        reg_wr <= 0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge ref_clk);
        reg_rd <= 0;
        #1;
        rdata = reg_rdata;
    endtask

    task automatic wait_start(output logic [9:0] v);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (slot_start !== 1'b1 && n < 2000);
        v = slot_count;
        `CHK(slot_start, 1'b1, "no slot start")
    endtask

    // Pulse one error input, then read the status word straight after
    task pulse_err(input logic dma);
        @(posedge ref_clk);
        clk_fail <= !dma;
        dma_err <= dma;
        @(posedge ref_clk);
        clk_fail <= 0;
        dma_err <= 0;
        reg_addr <= `TSSC_OFS_STATUS;
        reg_rd <= 1;
        @(posedge ref_clk);
        reg_rd <= 0;
        #1;
        rdata = reg_rdata;
    endtask

    // ==========================================
    // Scenarios
    task t_regs;
        rd(`TSSC_OFS_STATUS);
        `CHK(rdata, 32'h8, "status after reset")
        wr(`TSSC_OFS_SLOT, 32'hffffffff);
        rd(`TSSC_OFS_SLOT);
        `CHK(rdata, 32'h17f, "slot after reset or write")
        rd(8'h10);
        `CHK(rdata, 32'h0, "unmapped read")
    endtask

    task t_flags;
        wr(`TSSC_OFS_INT_EN, 32'h87);
        pulse_err(0);
        `CHK(rdata, 32'h10c, "clock fail flag")
        `CHK(tx_int, 1'b1, "interrupt not raised")
        wr(`TSSC_OFS_STATUS, 32'h0);
        rd(`TSSC_OFS_STATUS);
        `CHK(rdata, 32'h10c, "zero write cleared")
        wr(`TSSC_OFS_INT_EN, 32'h0);
        rd(`TSSC_OFS_INT_EN);
        `CHK(tx_int, 1'b0, "masked interrupt")
        wr(`TSSC_OFS_STATUS, 32'h4);
        rd(`TSSC_OFS_STATUS);
        `CHK(rdata, 32'h8, "one write left flag")
        pulse_err(1);
        `CHK(rdata, 32'h188, "dma flag summary")
        wr(`TSSC_OFS_STATUS, 32'h80);
        wr(`TSSC_OFS_INT_EN, 32'h87);
    endtask

    task t_frames;
        wr(`TSSC_OFS_FRAME_CFG, 32'h80010001);
        feed <= 1;
        link_run <= 1;
        wait_start(c);
        wait_start(c);
        wr(`TSSC_OFS_STATUS, 32'h87);
        for (int i = 0; i < 6; i++) begin
            wait_start(c);
            `CHK(c, (i % 2 == 1) ? 10'h1 : 10'h0, "slot sequence")
        end
        rd(`TSSC_OFS_STATUS);
        `CHK(rdata & 32'h107, 32'h0, "false error flag")
        feed <= 0;
        wait_start(c);
        wait_start(c);
        rd(`TSSC_OFS_STATUS);
        `CHK(rdata[0], 1'b1, "underrun missed")
        `CHK(tx_int, 1'b1, "underrun interrupt")
        feed <= 1;
        repeat (2) wait_start(c);
        wr(`TSSC_OFS_STATUS, 32'h1);
        repeat (2) wait_start(c);
        rd(`TSSC_OFS_STATUS);
        `CHK(rdata[0], 1'b0, "underrun not cleared")
        early <= 1;
        repeat (4) wait_start(c);
        early <= 0;
        rd(`TSSC_OFS_STATUS);
        `CHK(rdata[1], 1'b1, "early sync missed")
    endtask

    task t_dit;
        link_run <= 0;
        repeat (100) @(posedge ref_clk);
        wr(`TSSC_OFS_FRAME_CFG, 32'h0);
        rd(`TSSC_OFS_SLOT);
        `CHK(rdata, 32'h17f, "slot in transmitter reset")
        frame_bits <= 10'h300;
        wr(`TSSC_OFS_FRAME_CFG, 32'h80010100);
        link_run <= 1;
        wait_start(c);
        `CHK(c, 10'h0, "first block slot")
        repeat (383) wait_start(c);
        `CHK(c, 10'h17f, "last block slot")
        wait_start(c);
        `CHK(c, 10'h0, "block wrap")
    endtask

    task final_report;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #900000;
        failures++;
        $display("FAIL %0t watchdog expired", $time);
        final_report;
    end

    initial begin
        rst = 1;
        reg_wr = 0;
        reg_rd = 0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        clk_fail = 0;
        dma_err = 0;
        feed = 0;
        link_run = 0;
        early = 0;
        frame_bits = 10'h4;
        repeat (6) @(posedge ref_clk);
        rst <= 0;
        t_regs;
        t_flags;
        t_frames;
        t_dit;
        final_report;
    end
endmodule
